// *** src/frl_pkg.sv ***
package frl_pkg;

  // ==========================================================
  // clock and loader window
  // ==========================================================
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LOADER_WINDOW_MS = 3000;
  localparam int unsigned LOADER_WINDOW_CYCLES = (CLK_HZ / 1000) * LOADER_WINDOW_MS;
  localparam int unsigned WIN_CNT_W = 25;

  // ==========================================================
  // characters on the serial link
  // ==========================================================
  localparam logic [7:0] CH_RESET = 8'h19;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_K = 8'h6B;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [1:0] ACK_LAST = 2'h3;

  // ==========================================================
  // record layout, byte positions after the colon
  // ==========================================================
  localparam logic [8:0] REC_POS_LEN = 9'h000;
  localparam logic [8:0] REC_POS_ADDR_HI = 9'h001;
  localparam logic [8:0] REC_POS_ADDR_LO = 9'h002;
  localparam logic [8:0] REC_POS_TYPE = 9'h003;
  localparam logic [8:0] REC_POS_DATA = 9'h004;
  localparam logic [7:0] REC_TYPE_DATA = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HEX,
    ST_CHECK,
    ST_WRITE,
    ST_ACK,
    ST_CLOSED
  } frl_state_t;

  // returns {valid, nibble} for an ASCII hex digit
  function automatic logic [4:0] frl_hex_val(input logic [7:0] c);
    logic [4:0] r;
    r = 5'h00;
    if (c >= 8'h30 && c <= 8'h39)
    begin
      r = {1'b1, 4'(c - 8'h30)};
    end
    else if (c >= 8'h41 && c <= 8'h46)
    begin
      r = {1'b1, 4'(c - 8'h37)};
    end
    else if (c >= 8'h61 && c <= 8'h66)
    begin
      r = {1'b1, 4'(c - 8'h57)};
    end
    return r;
  endfunction : frl_hex_val

  function automatic logic [7:0] frl_ack_char(input logic [1:0] idx);
    logic [7:0] r;
    r = CH_O;
    unique case (idx)
      2'h0: r = CH_O;
      2'h1: r = CH_K;
      2'h2: r = CH_CR;
      2'h3: r = CH_LF;
    endcase
    return r;
  endfunction : frl_ack_char

endpackage : frl_pkg

// *** src/frl_byte_if.sv ***
`timescale 1ns/1ps
interface frl_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : frl_byte_if

// *** src/frl_skid_buf.sv ***
`timescale 1ns/1ps
module frl_skid_buf
  import frl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  frl_byte_if.snk in_if,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i
);

  // ==========================================================
  // two-entry buffer: output stage plus one skid stage
  // ==========================================================
  logic skid_valid_reg;
  logic [7:0] skid_data_reg;
  logic in_fire;
  logic out_fire;

  assign in_fire = in_if.valid && in_if.ready;
  assign out_fire = out_valid_o && out_ready_i;
  // ready only while the skid stage is empty, so a stall loses nothing
  assign in_if.ready = !skid_valid_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= 8'h00;
    end
    else if (!out_valid_o || out_fire)
    begin
      out_valid_o <= skid_valid_reg || in_fire;
      out_data_o <= skid_valid_reg ? skid_data_reg : in_if.data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      skid_valid_reg <= 1'b0;
      skid_data_reg <= 8'h00;
    end
    else if (in_fire && out_valid_o && !out_fire)
    begin
      skid_valid_reg <= 1'b1;
      skid_data_reg <= in_if.data;
    end
    else if (out_fire)
    begin
      skid_valid_reg <= 1'b0;
    end
  end

endmodule : frl_skid_buf

// *** src/frl_loader.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - after every reset the loader stays open a few seconds accepting records
// - a colon starts a new hex record; following characters form it
// - a good record is answered with O, k, then line terminator
// - with no character received for a few seconds the loader closes and restarts
// - record data is written into program memory at its address
// - reply terminator is 0x0D then 0x0A
module frl_loader
  import frl_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = LOADER_WINDOW_CYCLES
)
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output logic PMEM_WE_O,
  output logic [15:0] PMEM_ADDR_O,
  output logic [7:0] PMEM_DATA_O,
  output logic LOADER_ACTIVE_O,
  output logic RESTART_O
);

  // ==========================================================
  // state
  // ==========================================================
  frl_state_t state_reg;
  logic [7:0] rec_buf [0:255];
  logic [8:0] byte_idx_reg;
  logic nib_hi_reg;
  logic [3:0] hi_nib_reg;
  logic [7:0] sum_reg;
  logic [7:0] len_reg;
  logic [15:0] base_reg;
  logic [7:0] type_reg;
  logic [7:0] wr_idx_reg;
  logic [1:0] ack_idx_reg;
  logic [WIN_CNT_W-1:0] win_cnt_reg;
  logic rx_fire;
  logic [4:0] hv;
  logic [7:0] rx_byte;
  logic win_expired;
  logic host_reset;

  frl_byte_if tx_if ();

  assign rx_fire = RX_VALID_I && RX_READY_O;
  assign hv = frl_hex_val(RX_DATA_I);
  assign rx_byte = {hi_nib_reg, hv[3:0]};
  // an unfinished record also lets the window run out
  assign win_expired = (state_reg == ST_IDLE || state_reg == ST_HEX) &&
                       (win_cnt_reg == WIN_CNT_W'(WINDOW_CYCLES - 1)) && !rx_fire;
  assign host_reset = rx_fire && (RX_DATA_I == CH_RESET) &&
                      (state_reg == ST_IDLE || state_reg == ST_CLOSED);

  // ==========================================================
  // acknowledgement path
  // ==========================================================
  assign tx_if.valid = (state_reg == ST_ACK);
  assign tx_if.data = frl_ack_char(ack_idx_reg);

  frl_skid_buf u_tx_buf (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .in_if(tx_if.snk),
    .out_valid_o(TX_VALID_O),
    .out_data_o(TX_DATA_O),
    .out_ready_i(TX_READY_I)
  );

  // ==========================================================
  // record parser and sequencer
  // ==========================================================
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_IDLE;
      RX_READY_O <= 1'b1;
      byte_idx_reg <= 9'h000;
      nib_hi_reg <= 1'b1;
      hi_nib_reg <= 4'h0;
      sum_reg <= 8'h00;
      len_reg <= 8'h00;
      base_reg <= 16'h0000;
      type_reg <= 8'h00;
      wr_idx_reg <= 8'h00;
      ack_idx_reg <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_HEX:
        begin
          if (win_expired)
            state_reg <= ST_CLOSED;
          else if (rx_fire && RX_DATA_I == CH_COLON)
          begin
            state_reg <= ST_HEX;
            byte_idx_reg <= 9'h000;
            nib_hi_reg <= 1'b1;
            sum_reg <= 8'h00;
          end
          else if (rx_fire && state_reg == ST_HEX)
          begin
            if (!hv[4])
              state_reg <= ST_IDLE;
            else if (nib_hi_reg)
            begin
              hi_nib_reg <= hv[3:0];
              nib_hi_reg <= 1'b0;
            end
            else
            begin
              nib_hi_reg <= 1'b1;
              sum_reg <= sum_reg + rx_byte;
              byte_idx_reg <= byte_idx_reg + 9'h001;
              if (byte_idx_reg == REC_POS_LEN)
                len_reg <= rx_byte;
              else if (byte_idx_reg == REC_POS_ADDR_HI)
                base_reg[15:8] <= rx_byte;
              else if (byte_idx_reg == REC_POS_ADDR_LO)
                base_reg[7:0] <= rx_byte;
              else if (byte_idx_reg == REC_POS_TYPE)
                type_reg <= rx_byte;
              if (byte_idx_reg == {1'b0, len_reg} + REC_POS_DATA &&
                  byte_idx_reg > REC_POS_TYPE)
              begin
                state_reg <= ST_CHECK;
                RX_READY_O <= 1'b0;
              end
            end
          end
        end
        ST_CHECK:
        begin
          wr_idx_reg <= 8'h00;
          ack_idx_reg <= 2'h0;
          if (sum_reg != 8'h00)
          begin
            state_reg <= ST_IDLE;
            RX_READY_O <= 1'b1;
          end
          else if (type_reg == REC_TYPE_DATA && len_reg != 8'h00)
            state_reg <= ST_WRITE;
          else
            state_reg <= ST_ACK;
        end
        ST_WRITE:
        begin
          wr_idx_reg <= wr_idx_reg + 8'h01;
          if (wr_idx_reg == len_reg - 8'h01)
            state_reg <= ST_ACK;
        end
        ST_ACK:
        begin
          if (tx_if.ready)
          begin
            ack_idx_reg <= ack_idx_reg + 2'h1;
            if (ack_idx_reg == ACK_LAST)
            begin
              state_reg <= ST_IDLE;
              RX_READY_O <= 1'b1;
            end
          end
        end
        ST_CLOSED: state_reg <= ST_CLOSED;
      endcase
    end
  end

  // data bytes held until the checksum has been seen
  always_ff @(posedge SYS_CLK_I)
  begin
    if (rx_fire && state_reg == ST_HEX && hv[4] && !nib_hi_reg &&
        byte_idx_reg >= REC_POS_DATA)
      rec_buf[8'(byte_idx_reg - REC_POS_DATA)] <= rx_byte;
  end

  // ==========================================================
  // program memory write port
  // ==========================================================
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      PMEM_WE_O <= 1'b0;
      PMEM_ADDR_O <= 16'h0000;
      PMEM_DATA_O <= 8'h00;
    end
    else
    begin
      PMEM_WE_O <= (state_reg == ST_WRITE);
      PMEM_ADDR_O <= base_reg + {8'h00, wr_idx_reg};
      PMEM_DATA_O <= rec_buf[wr_idx_reg];
    end
  end

  // ==========================================================
  // loader window and restart
  // ==========================================================
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      win_cnt_reg <= '0;
      LOADER_ACTIVE_O <= 1'b1;
      RESTART_O <= 1'b0;
    end
    else
    begin
      if (rx_fire || !(state_reg inside {ST_IDLE, ST_HEX}))
        win_cnt_reg <= '0;
      else
        win_cnt_reg <= win_cnt_reg + WIN_CNT_W'(1);
      if (win_expired)
        LOADER_ACTIVE_O <= 1'b0;
      RESTART_O <= win_expired || host_reset;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  logic ack_fire;
  assign ack_fire = tx_if.valid && tx_if.ready;

  sequence s_k_next;
    tx_if.valid && tx_if.data == CH_K;
  endsequence
  sequence s_lf_next;
    tx_if.valid && tx_if.data == CH_LF;
  endsequence

  property p_window_open;
    @(posedge SYS_CLK_I) $rose(RST_N_I) |-> LOADER_ACTIVE_O [*8];
  endproperty
  a_window_open: assert property (p_window_open) else $error("loader closed at reset");
  property p_host_reset;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I) host_reset |=> RESTART_O;
  endproperty
  a_host_reset: assert property (p_host_reset) else $error("reset byte ignored");
  property p_colon;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      rx_fire && RX_DATA_I == CH_COLON && !win_expired &&
      (state_reg == ST_IDLE || state_reg == ST_HEX)
      |=> state_reg == ST_HEX && byte_idx_reg == 9'h000 && sum_reg == 8'h00;
  endproperty
  a_colon: assert property (p_colon) else $error("colon did not start record");
  property p_ok_order;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ack_fire && tx_if.data == CH_O |=> s_k_next;
  endproperty
  a_ok_order: assert property (p_ok_order) else $error("k did not follow O");
  property p_crlf;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      ack_fire && tx_if.data == CH_CR |=> s_lf_next;
  endproperty
  a_crlf: assert property (p_crlf) else $error("LF did not follow CR");
  property p_no_rx_in_ack;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      state_reg inside {ST_CHECK, ST_WRITE, ST_ACK} |-> !RX_READY_O;
  endproperty
  a_no_rx_in_ack: assert property (p_no_rx_in_ack) else $error("rx open mid record");
  // a reset byte may arrive right after closing and pulse restart again
  property p_timeout;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      win_expired |=> RESTART_O && !LOADER_ACTIVE_O ##1 state_reg == ST_CLOSED &&
                      RESTART_O == $past(host_reset);
  endproperty
  a_timeout: assert property (p_timeout) else $error("window expiry mishandled");
  property p_write;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      PMEM_WE_O |-> type_reg == REC_TYPE_DATA && sum_reg == 8'h00 &&
                    PMEM_ADDR_O == base_reg + {8'h00, wr_idx_reg - 8'h01};
  endproperty
  a_write: assert property (p_write) else $error("bad program memory write");
  property p_bad_sum;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      state_reg == ST_CHECK && sum_reg != 8'h00
      |=> state_reg == ST_IDLE && !tx_if.valid ##1 !PMEM_WE_O;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad record acted on");

endmodule : frl_loader

// *** tb/frl_host_model.sv ***
`timescale 1ns/1ps
module frl_host_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  // ====================
  // host byte queues
  // ====================
  logic [7:0] q [$];
  logic [7:0] got [$];

  initial
  begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  task automatic push(input logic [7:0] b [$]);
    foreach (b[i]) q.push_back(b[i]);
  endtask : push

  // ====================
  // send and collect
  // ====================
  always @(posedge clk_i)
  begin
    tx_ready_o <= ($urandom % 3) != 0;
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    if (!rst_n_i)
      rx_valid_o <= 1'b0;
    else
    begin
      if (rx_valid_o && rx_ready_i)
        void'(q.pop_front());
      // byte held until taken; a released line toggles
      if (q.size() > 0)
      begin
        rx_valid_o <= 1'b1;
        rx_data_o <= q[0];
      end
      else
      begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
      end
    end
  end
endmodule : frl_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ====================
  // clock, dut, host
  // ====================
  localparam int WIN = 200;
  typedef logic [7:0] frl_bq_t [$];
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] rx_data, tx_data, pmem_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, pmem_we, loader_active, restart;
  logic [15:0] pmem_addr;
  logic [7:0] mem [logic [15:0]];
  int failures = 0;
  int n_tests = 0;
  int n_wr = 0;
  int n_rst = 0;

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  frl_loader #(.WINDOW_CYCLES(WIN)) i_dut (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
    .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready),
    .TX_DATA_O(tx_data), .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready),
    .PMEM_WE_O(pmem_we), .PMEM_ADDR_O(pmem_addr), .PMEM_DATA_O(pmem_data),
    .LOADER_ACTIVE_O(loader_active), .RESTART_O(restart));

  frl_host_model i_host (.clk_i(sys_clk), .rst_n_i(rst_n), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));

  always @(posedge sys_clk)
  begin
    if (rst_n && pmem_we)
    begin
      mem[pmem_addr] = pmem_data;
      n_wr++;
    end
    if (rst_n && restart)
      n_rst++;
  end

  // ====================
  // helpers
  // ====================
  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp)
    begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hexc

  function automatic frl_bq_t mk_rec(input logic [7:0] ty, input logic [15:0] a,
                                     input frl_bq_t d, input logic [7:0] bad, input bit lc);
    frl_bq_t b, s;
    logic [7:0] sum;
    logic [7:0] cs;
    b = {8'(d.size()), a[15:8], a[7:0], ty};
    foreach (d[i]) b.push_back(d[i]);
    sum = 8'h00;
    foreach (b[i]) sum += b[i];
    b.push_back(8'h00 - sum + bad);
    cs = lc ? 8'h20 : 8'h00;
    s = {8'h3A};
    foreach (b[i])
    begin
      s.push_back(hexc(b[i][7:4]) | cs);
      s.push_back(hexc(b[i][3:0]) | cs);
    end
    return s;
  endfunction : mk_rec

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic do_rec(input logic [7:0] ty, input logic [15:0] a, input int len,
                        input logic [7:0] bad, input bit lc, input bit ok);
    frl_bq_t d;
    int w0, t;
    logic [7:0] exp [4];
    exp = '{8'h4F, 8'h6B, 8'h0D, 8'h0A};
    for (t = 0; t < len; t++) d.push_back(8'($urandom));
    w0 = n_wr;
    @(negedge sys_clk);
    i_host.got.delete();
    i_host.push(mk_rec(ty, a, d, bad, lc));
    for (t = 0; t < (ok ? 300 : 100) && i_host.got.size() < 4; t++) @(posedge sys_clk);
    if (!ok)
      repeat (100 - t) @(posedge sys_clk);
    chk_cnt("reply length", ok ? 4 : 0, i_host.got.size());
    foreach (i_host.got[i]) chk_val("reply byte", exp[i], i_host.got[i]);
    chk_cnt("writes", (ok && ty == 8'h00) ? len : 0, n_wr - w0);
    if (ok && ty == 8'h00)
      foreach (d[i]) chk_val("memory", d[i], mem[a + 16'(i)]);
    chk_val("ready after record", 8'h01, 8'(rx_ready));
  endtask : do_rec

  task automatic conclude();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // ====================
  // tests
  // ====================
  initial
  begin
    frl_bq_t s;
    int r0;
    void'($urandom(32'h5ceb3a7f));
    do_reset();
    @(negedge sys_clk);
    chk_val("open after reset", 8'h01, 8'(loader_active));
    do_rec(8'h00, 16'hFFFC, 8, 8'h00, 1'b0, 1'b1);
    repeat (6) do_rec(8'h00, 16'($urandom), 1 + $urandom % 8, 8'h00, $urandom % 2, 1'b1);
    do_rec(8'h00, 16'h0100, 4, 8'h00, 1'b0, 1'b1);
    do_rec(8'h00, 16'h0100, 4, 8'h00, 1'b1, 1'b1);
    do_rec(8'h00, 16'h0200, 3, 8'h01, 1'b0, 1'b0);
    do_rec(8'h01, 16'h0000, 0, 8'h00, 1'b0, 1'b1);
    do_rec(8'h00, 16'h0300, 0, 8'h00, 1'b0, 1'b1);
    s = {8'h55, 8'h3A, 8'h31, 8'h47, 8'h3A, 8'h31};
    i_host.push(s);
    do_rec(8'h00, 16'h0400, 2, 8'h00, 1'b0, 1'b1);
    chk_val("still open", 8'h01, 8'(loader_active));
    r0 = n_rst;
    s = {8'h19};
    i_host.push(s);
    repeat (20) @(posedge sys_clk);
    chk_cnt("restart on reset byte", r0 + 1, n_rst);
    s = {8'h3A, 8'h31};
    i_host.push(s);
    repeat (WIN + 20) @(posedge sys_clk);
    chk_val("closed mid record", 8'h00, 8'(loader_active));
    do_reset();
    repeat (WIN - 20) @(posedge sys_clk);
    chk_val("open in window", 8'h01, 8'(loader_active));
    repeat (40) @(posedge sys_clk);
    chk_val("closed after window", 8'h00, 8'(loader_active));
    chk_cnt("restart after window", r0 + 3, n_rst);
    do_rec(8'h00, 16'h0500, 2, 8'h00, 1'b0, 1'b0);
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("mismatch watchdog expected finish seen timeout");
    conclude();
  end
endmodule : tb_top
